/* core/tsb_pkg.sv */
// constants for the tag buffer status register bank
package tsb_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int LINK_W = 11;

  // register offsets
  localparam logic [7:0] OFS_BUFFER_FILL_LEVEL = 8'h0C;
  localparam logic [7:0] OFS_BUFFER_FLAG_STATUS = 8'h0D;
  localparam logic [7:0] OFS_LAST_READER_ADDRESS = 8'h0E;
  localparam logic [7:0] OFS_REVISION_MAJOR_NUMBER = 8'h1E;
  localparam logic [7:0] OFS_REVISION_MINOR_NUMBER = 8'h1F;

  // field positions
  localparam int FILL_INVALID_BIT = 7;
  localparam int FILL_COUNT_MSB = 5;
  localparam int FLAG_RADIO_BUSY_BIT = 5;
  localparam int FLAG_RADIO_PEND_BIT = 4;
  localparam int FLAG_HOST_PEND_BIT = 3;
  localparam int FLAG_UNDERRUN_BIT = 1;
  localparam int FLAG_OVERRUN_BIT = 0;

  // reset values and the last-address busy value
  localparam logic [7:0] RST_BUFFER_FILL_LEVEL = 8'h00;
  localparam logic [7:0] RST_BUFFER_FLAG_STATUS = 8'h00;
  localparam logic [7:0] RST_LAST_READER_ADDRESS = 8'h00;
  localparam logic [7:0] LAST_ADDR_BUSY = 8'hFF;

  // arbitrary revision values
  localparam logic [7:0] REV_MAJOR_DEF = 8'h05;
  localparam logic [7:0] REV_MINOR_DEF = 8'h03;

  // buffer depth and settle time of the invalid flag
  localparam logic [6:0] BUF_DEPTH_DEF = 7'h20;
  localparam logic [1:0] CHG_HOLD = 2'h2;
endpackage

/* core/tsb_pin_sync.sv */
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module tsb_pin_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic ce,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_r
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
  } tsb_sync_type;

  tsb_sync_type s_r;
  tsb_sync_type s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = pin_in;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    // a bit moves once stages two and three agree
    s_nxt.level = (~(s_r.s2 ^ s_r.s3) & s_r.s3) | ((s_r.s2 ^ s_r.s3) & s_r.level);
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign level_r = s_r.level;
endmodule

/* core/tsb_status_regs.sv */
// buffer status, last reader address and revision registers
// What this block does
// - bit 7 of the fill register is high while the buffer contents are changing.
// - bits 5 to 0 of the fill register count buffer bytes from the reader not yet read.
// - both buffer status registers clear on power-up, restore-defaults, flush and idle/halt.
// - bit 1 of the flag register sets when the host reads more bytes than are held.
// - bit 0 of the flag register sets when more bytes are written than fit.
// - flag register bits 5, 4 and 3 show radio busy, radio data and host data pending.
// - no host-side busy flag is reported in the flag register.
// - the last-address register takes the address of each reader memory access.
// - the reader address is stored as a full 8 bits, even beyond the memory space.
// - the last-address register reads FFh while it is being updated.
// - the last-address register clears on power-up, restore-defaults and flush only.
// - a read-only register holds the major revision number.
// - a read-only register holds the minor revision number.
// - the buffer error interrupt rises whenever an overflow or underflow is recorded.
`timescale 1ns/1ps
module tsb_status_regs
  import tsb_pkg::*;
#(
  parameter logic [6:0] BUF_DEPTH = tsb_pkg::BUF_DEPTH_DEF,
  parameter logic [7:0] REV_MAJOR = tsb_pkg::REV_MAJOR_DEF,
  parameter logic [7:0] REV_MINOR = tsb_pkg::REV_MINOR_DEF
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic ce,
  input wire logic host_rd_en,
  input wire logic [tsb_pkg::ADDR_W-1:0] host_rd_addr,
  input wire logic host_buf_pop,
  input wire logic cmd_set_default,
  input wire logic cmd_clear_buffer,
  input wire logic idle_halt_cmd,
  input wire logic radio_side_busy,
  input wire logic radio_data_pending,
  input wire logic host_data_pending,
  input wire logic link_clk,
  input wire logic link_push,
  input wire logic link_access,
  input wire logic [7:0] link_addr,
  output logic [tsb_pkg::DATA_W-1:0] host_rd_data_r,
  output logic host_rd_valid_r,
  output logic storage_fault_irq_r
);
  typedef enum logic [1:0] {
    LA_IDLE = 2'b01,
    LA_UPD = 2'b10
  } tsb_la_state_type;

  typedef struct packed {
    logic [5:0] count;
    logic len_invalid;
    logic [1:0] chg_cnt;
    logic buf_ovr;
    logic buf_unf;
    logic radio_busy;
    logic radio_pend;
    logic host_pend;
    logic [7:0] last_addr;
    logic [7:0] addr_hold;
    tsb_la_state_type la_state;
    logic clk_prev;
    logic [7:0] rd_data;
    logic rd_valid;
    logic fault_irq;
  } tsb_state_type;

  tsb_state_type s_r;
  tsb_state_type s_nxt;
  logic [LINK_W-1:0] link_lvl;
  logic lk_clk;
  logic lk_push;
  logic lk_access;
  logic [7:0] lk_addr;
  logic link_edge;
  logic push;
  logic pop;
  logic ovr_ev;
  logic unf_ev;
  logic changing;
  logic clr_buf;
  logic clr_la;

  // link pins pass the three-stage filter
  tsb_pin_sync #(
    .W(LINK_W)
  ) u_link_sync (
    .clock(clock),
    .reset(reset),
    .ce(ce),
    .pin_in({link_clk, link_push, link_access, link_addr}),
    .level_r(link_lvl)
  );

  assign lk_clk = link_lvl[10];
  assign lk_push = link_lvl[9];
  assign lk_access = link_lvl[8];
  assign lk_addr = link_lvl[7:0];

  // register read decode
  function automatic logic [7:0] read_mux(input logic [7:0] a, input tsb_state_type st);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      OFS_BUFFER_FILL_LEVEL: begin
        v[FILL_INVALID_BIT] = st.len_invalid;
        v[FILL_COUNT_MSB:0] = st.count;
      end
      OFS_BUFFER_FLAG_STATUS: begin
        v[FLAG_RADIO_BUSY_BIT] = st.radio_busy;
        v[FLAG_RADIO_PEND_BIT] = st.radio_pend;
        v[FLAG_HOST_PEND_BIT] = st.host_pend;
        v[FLAG_UNDERRUN_BIT] = st.buf_unf;
        v[FLAG_OVERRUN_BIT] = st.buf_ovr;
      end
      OFS_LAST_READER_ADDRESS: v = st.last_addr;
      OFS_REVISION_MAJOR_NUMBER: v = REV_MAJOR;
      OFS_REVISION_MINOR_NUMBER: v = REV_MINOR;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb begin
    s_nxt = s_r;
    s_nxt.clk_prev = lk_clk;
    link_edge = lk_clk & ~s_r.clk_prev;
    push = link_edge & lk_push;
    pop = host_buf_pop;
    clr_la = cmd_set_default | cmd_clear_buffer;
    clr_buf = clr_la | idle_halt_cmd;
    ovr_ev = push & ~pop & ({1'b0, s_r.count} >= BUF_DEPTH);
    unf_ev = pop & ~push & (s_r.count == 6'h00);
    changing = push | pop;
    // byte count
    if (push && !pop && !ovr_ev) begin
      s_nxt.count = s_r.count + 6'h01;
    end else if (pop && !push && !unf_ev) begin
      s_nxt.count = s_r.count - 6'h01;
    end
    // invalid flag spans the change
    if (changing) begin
      s_nxt.chg_cnt = CHG_HOLD;
    end else if (s_r.chg_cnt != 2'h0) begin
      s_nxt.chg_cnt = s_r.chg_cnt - 2'h1;
    end
    s_nxt.len_invalid = (s_nxt.chg_cnt != 2'h0);
    // sticky error flags
    s_nxt.buf_ovr = s_r.buf_ovr | ovr_ev;
    s_nxt.buf_unf = s_r.buf_unf | unf_ev;
    s_nxt.fault_irq = ovr_ev | unf_ev;
    // handshake state, no host busy bit
    s_nxt.radio_busy = radio_side_busy;
    s_nxt.radio_pend = radio_data_pending;
    s_nxt.host_pend = host_data_pending;
    // last address update
    case (s_r.la_state)
      LA_IDLE: begin
        if (link_edge && lk_access) begin
          s_nxt.addr_hold = lk_addr;
          s_nxt.last_addr = LAST_ADDR_BUSY;
          s_nxt.la_state = LA_UPD;
        end
      end
      LA_UPD: begin
        s_nxt.last_addr = s_r.addr_hold;
        s_nxt.la_state = LA_IDLE;
      end
      default: s_nxt.la_state = LA_IDLE;
    endcase
    // command clears, a new error still sets its flag
    if (clr_buf) begin
      s_nxt.count = RST_BUFFER_FILL_LEVEL[5:0];
      s_nxt.chg_cnt = 2'h0;
      s_nxt.len_invalid = RST_BUFFER_FILL_LEVEL[FILL_INVALID_BIT];
      s_nxt.radio_busy = RST_BUFFER_FLAG_STATUS[FLAG_RADIO_BUSY_BIT];
      s_nxt.radio_pend = RST_BUFFER_FLAG_STATUS[FLAG_RADIO_PEND_BIT];
      s_nxt.host_pend = RST_BUFFER_FLAG_STATUS[FLAG_HOST_PEND_BIT];
      s_nxt.buf_ovr = ovr_ev;
      s_nxt.buf_unf = unf_ev;
    end
    if (clr_la) begin
      s_nxt.last_addr = RST_LAST_READER_ADDRESS;
      s_nxt.la_state = LA_IDLE;
    end
    // read port
    s_nxt.rd_valid = host_rd_en;
    s_nxt.rd_data = host_rd_en ? read_mux(host_rd_addr, s_r) : 8'h00;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_r <= '0;
      s_r.la_state <= LA_IDLE;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign host_rd_data_r = s_r.rd_data;
  assign host_rd_valid_r = s_r.rd_valid;
  assign storage_fault_irq_r = s_r.fault_irq;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  property p_invalid_on_change;
    (ce && changing && !clr_buf) |=> s_r.len_invalid;
  endproperty
  a_invalid_on_change: assert property (p_invalid_on_change) else $error("invalid low");

  sequence s_quiet;
    ce && !changing && !clr_buf;
  endsequence

  property p_invalid_span;
    (ce && changing && !clr_buf) ##1 s_quiet ##1 s_quiet |=> !s_r.len_invalid;
  endproperty
  a_invalid_span: assert property (p_invalid_span) else $error("invalid held too long");

  property p_count_up;
    (ce && push && !pop && !ovr_ev && !clr_buf) |=> (s_r.count == $past(s_r.count) + 6'h01);
  endproperty
  a_count_up: assert property (p_count_up) else $error("count did not rise");

  property p_count_down;
    (ce && pop && !push && !unf_ev && !clr_buf) |=> (s_r.count == $past(s_r.count) - 6'h01);
  endproperty
  a_count_down: assert property (p_count_down) else $error("count did not fall");

  property p_clear_buf;
    (ce && clr_buf) |=> (s_r.count == 6'h00 && !s_r.len_invalid && !s_r.radio_busy);
  endproperty
  a_clear_buf: assert property (p_clear_buf) else $error("buffer status not cleared");

  property p_underrun;
    (ce && unf_ev) |=> (s_r.buf_unf && s_r.count == 6'h00);
  endproperty
  a_underrun: assert property (p_underrun) else $error("underrun not flagged");

  property p_overrun;
    (ce && ovr_ev && !clr_buf) |=> (s_r.buf_ovr && s_r.count == $past(s_r.count));
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_flag_read;
    (ce && host_rd_en && host_rd_addr == OFS_BUFFER_FLAG_STATUS) |=>
      (host_rd_valid_r && host_rd_data_r[7:6] == 2'b00 && host_rd_data_r[2] == 1'b0
       && host_rd_data_r[5] == $past(s_r.radio_busy));
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("flag read wrong");

  property p_hs_copy;
    (ce && !clr_buf) |=>
      (s_r.radio_pend == $past(radio_data_pending) && s_r.host_pend == $past(host_data_pending));
  endproperty
  a_hs_copy: assert property (p_hs_copy) else $error("handshake copy wrong");

  sequence s_addr_start;
    ce && link_edge && lk_access && !clr_la && s_r.la_state == LA_IDLE;
  endsequence

  sequence s_addr_busy;
    s_r.last_addr == LAST_ADDR_BUSY && s_r.la_state == LA_UPD;
  endsequence

  sequence s_addr_done;
    s_addr_start ##1 (ce && !clr_la);
  endsequence

  property p_addr_update;
    s_addr_start |=> s_addr_busy;
  endproperty
  a_addr_update: assert property (p_addr_update) else $error("address busy missing");

  property p_addr_done;
    s_addr_done |=> (s_r.last_addr == $past(s_r.addr_hold));
  endproperty
  a_addr_done: assert property (p_addr_done) else $error("last address not updated");

  property p_addr_full;
    (ce && link_edge && lk_access && !clr_la && s_r.la_state == LA_IDLE) |=>
      (s_r.addr_hold == $past(lk_addr));
  endproperty
  a_addr_full: assert property (p_addr_full) else $error("address not held whole");

  property p_idle_keeps_addr;
    (ce && idle_halt_cmd && !clr_la && s_r.la_state == LA_IDLE && !(link_edge && lk_access))
      |=> $stable(s_r.last_addr);
  endproperty
  a_idle_keeps_addr: assert property (p_idle_keeps_addr) else $error("address changed");

  property p_clear_addr;
    (ce && clr_la) |=> (s_r.last_addr == 8'h00);
  endproperty
  a_clear_addr: assert property (p_clear_addr) else $error("address not cleared");

  property p_rev_read;
    (ce && host_rd_en && host_rd_addr == OFS_REVISION_MAJOR_NUMBER) |=>
      (host_rd_data_r == REV_MAJOR);
  endproperty
  a_rev_read: assert property (p_rev_read) else $error("major revision wrong");

  property p_rev_minor;
    (ce && host_rd_en && host_rd_addr == OFS_REVISION_MINOR_NUMBER) |=>
      (host_rd_data_r == REV_MINOR);
  endproperty
  a_rev_minor: assert property (p_rev_minor) else $error("minor revision wrong");

  property p_fault_irq;
    (ce && (ovr_ev || unf_ev)) |=> (storage_fault_irq_r && (s_r.buf_ovr || s_r.buf_unf));
  endproperty
  a_fault_irq: assert property (p_fault_irq) else $error("fault interrupt missing");

  property p_irq_quiet;
    (ce && !ovr_ev && !unf_ev) |=> !storage_fault_irq_r;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("stray fault interrupt");
endmodule

/* verification/tsb_link_model.sv */
// reader-side link model, clock still between bytes
`timescale 1ns/1ps
module tsb_link_model (
  output logic link_clk,
  output logic link_push,
  output logic link_access,
  output logic [7:0] link_addr
);
  initial begin
    link_clk = 1'b0;
    link_push = 1'b0;
    link_access = 1'b0;
    link_addr = 8'h00;
  end
  // one byte or access per 125 ns link period
  task automatic send(input logic p, input logic a, input logic [7:0] ad);
    link_push = p;
    link_access = a;
    link_addr = ad;
    #62.5 link_clk = 1'b1;
    #62.5 link_clk = 1'b0;
    // released lines no longer hold the last value
    link_addr = ~ad;
    link_access = ~a;
    link_push = ~p;
  endtask
endmodule

/* verification/tsb_status_regs_tb.sv */
// self-checking bench for the status register bank
`timescale 1ns/1ps
module tsb_status_regs_tb;
  import tsb_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic rd_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic pop = 1'b0;
  logic c_def = 1'b0;
  logic c_clr = 1'b0;
  logic c_idle = 1'b0;
  logic rbusy = 1'b0;
  logic rpend = 1'b0;
  logic hpend = 1'b0;
  logic lclk, lpush, lacc, valid, irq;
  logic [7:0] laddr, rdata, v;
  int mismatches = 0;
  int tests_run = 0;
  int irqs = 0;
  int i0;
  always #5 clock = ~clock;
  always @(negedge clock) if (irq === 1'b1) irqs++;
  tsb_link_model link (.link_clk(lclk), .link_push(lpush), .link_access(lacc),
    .link_addr(laddr));
  tsb_status_regs #(.BUF_DEPTH(7'h04)) DUT (
    .clock(clock), .reset(reset), .ce(ce),
    .host_rd_en(rd_en), .host_rd_addr(addr), .host_buf_pop(pop),
    .cmd_set_default(c_def), .cmd_clear_buffer(c_clr), .idle_halt_cmd(c_idle),
    .radio_side_busy(rbusy), .radio_data_pending(rpend), .host_data_pending(hpend),
    .link_clk(lclk), .link_push(lpush), .link_access(lacc), .link_addr(laddr),
    .host_rd_data_r(rdata), .host_rd_valid_r(valid), .storage_fault_irq_r(irq));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    rd_en = 1'b1;
    addr = a;
    @(negedge clock);
    d = (valid === 1'b1) ? rdata : 8'hxx;
    rd_en = 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a, v);
    chk(v, e);
  endtask
  // re-read until the length is valid
  task automatic fill_ok(input logic [7:0] e);
    v = 8'h80;
    for (int n = 0; n < 10 && v[7] !== 1'b0; n++) rd(OFS_BUFFER_FILL_LEVEL, v);
    chk(v, e);
  endtask
  task automatic lk(input logic p, input logic a, input logic [7:0] ad);
    link.send(p, a, ad);
    repeat (8) @(negedge clock);
  endtask
  task automatic pop1();
    @(negedge clock);
    pop = 1'b1;
    @(negedge clock);
    pop = 1'b0;
  endtask
  task automatic cmd(input int i);
    @(negedge clock);
    c_def = (i == 0);
    c_clr = (i == 1);
    c_idle = (i == 2);
    @(negedge clock);
    {c_def, c_clr, c_idle} = 3'b000;
  endtask
  task automatic t_regs();
    rc(OFS_BUFFER_FILL_LEVEL, RST_BUFFER_FILL_LEVEL);
    rc(OFS_BUFFER_FLAG_STATUS, RST_BUFFER_FLAG_STATUS);
    rc(OFS_LAST_READER_ADDRESS, RST_LAST_READER_ADDRESS);
    rc(OFS_REVISION_MAJOR_NUMBER, REV_MAJOR_DEF);
    rc(OFS_REVISION_MINOR_NUMBER, REV_MINOR_DEF);
    rc(8'h10, 8'h00);
  endtask
  task automatic t_fill();
    repeat (3) lk(1'b1, 1'b0, 8'h00);
    fill_ok(8'h03);
    pop1();
    rd_en = 1'b1;
    addr = OFS_BUFFER_FILL_LEVEL;
    @(negedge clock);
    rd_en = 1'b0;
    chk(rdata, 8'h82);
    fill_ok(8'h02);
    // a pop while frozen is not taken
    @(negedge clock);
    ce = 1'b0;
    pop = 1'b1;
    @(negedge clock);
    pop = 1'b0;
    ce = 1'b1;
    fill_ok(8'h02);
  endtask
  task automatic t_over();
    i0 = irqs;
    repeat (3) lk(1'b1, 1'b0, 8'h00);
    fill_ok(8'h04);
    rc(OFS_BUFFER_FLAG_STATUS, 8'h01);
    chk(8'(irqs - i0), 8'h01);
    cmd(2);
    rc(OFS_BUFFER_FLAG_STATUS, 8'h00);
    rc(OFS_BUFFER_FILL_LEVEL, 8'h00);
  endtask
  task automatic t_under();
    i0 = irqs;
    pop1();
    repeat (2) @(negedge clock);
    chk(8'(irqs - i0), 8'h01);
    rc(OFS_BUFFER_FLAG_STATUS, 8'h02);
    rc(OFS_BUFFER_FILL_LEVEL, 8'h00);
  endtask
  task automatic t_hs();
    @(negedge clock);
    {rbusy, rpend, hpend} = 3'b111;
    rc(OFS_BUFFER_FLAG_STATUS, 8'h3A);
    @(negedge clock);
    {rbusy, rpend, hpend} = 3'b101;
    rc(OFS_BUFFER_FLAG_STATUS, 8'h2A);
    @(negedge clock);
    {rbusy, rpend, hpend} = 3'b000;
  endtask
  task automatic t_addr();
    logic seen_ff;
    seen_ff = 1'b0;
    @(negedge clock);
    rd_en = 1'b1;
    addr = OFS_LAST_READER_ADDRESS;
    fork
      link.send(1'b0, 1'b1, 8'hF3);
      repeat (25) begin
        @(negedge clock);
        if (valid === 1'b1 && rdata === LAST_ADDR_BUSY) seen_ff = 1'b1;
      end
    join
    rd_en = 1'b0;
    chk(rdata, 8'hF3);
    chk({7'h00, seen_ff}, 8'h01);
  endtask
  task automatic t_cmds();
    for (int i = 0; i < 3; i++) begin
      lk(1'b1, 1'b1, 8'h5A);
      cmd(i);
      rc(OFS_BUFFER_FILL_LEVEL, 8'h00);
      rc(OFS_LAST_READER_ADDRESS, (i == 2) ? 8'h5A : 8'h00);
    end
  endtask
  task automatic report_and_stop();
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    repeat (5) @(negedge clock);
    t_regs();
    t_fill();
    t_over();
    t_under();
    t_hs();
    t_addr();
    t_cmds();
    report_and_stop();
  end
  initial begin
    #100000;
    mismatches++;
    report_and_stop();
  end
endmodule
